// ---- hw/pwm_output_generator.sv ----
// multi-channel pwm output generator with timer and grouped bank channels
module pwm_output_generator
  import pwm_output_pkg::*;
(
  input wire logic clk, // 40 MHz clock
  input wire logic rst, // async reset, active high
  input wire logic cmd_valid, // command strobe, one cycle
  input wire logic [1:0] cmd_op, // command code
  input wire logic [4:0] cmd_pin, // pin index 0..25
  input wire logic [15:0] cmd_value, // period or duty value
  output logic cmd_refused, // command rejected this cycle
  output logic [25:0] pwm_out // pin levels, registered
);
  function automatic logic [3:0] period_slot(input logic [4:0] pin);
    if (pin >= PIN_BANK_B_FIRST)
      return SLOT_BANK_B;
    else if (pin >= PIN_BANK_A_FIRST)
      return SLOT_BANK_A;
    else
      return pin[3:0];
  endfunction : period_slot

  function automatic logic [15:0] active_len(input logic [15:0] duty, input logic [15:0] period);
    logic [31:0] prod;
    prod = 32'(duty) * 32'(period);
    return prod[31:16];
  endfunction : active_len

  logic [3:0] tick_cnt_q;
  logic tick;
  logic [15:0] period_q [PERIOD_SLOTS];
  logic [15:0] slot_cnt [PERIOD_SLOTS];
  logic [15:0] duty_q [PIN_COUNT];
  logic [25:0] pwm_en_q;
  logic [25:0] level_q;
  logic [25:0] out_q;
  logic [25:0] chan_active;

  // timebase prescaler
  assign tick = (tick_cnt_q == TICK_LAST);

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      tick_cnt_q <= TICK_CNT_RESET;
    else
      tick_cnt_q <= tick ? TICK_CNT_RESET : 4'(tick_cnt_q + 4'h1);
  end

  // command decode
  cmd_op_t op;
  logic pin_valid;
  logic pin_is_bank;
  logic pin_pwm_capable;
  logic op_is_pwm;
  logic period_in_range;
  logic [3:0] slot;
  logic cmd_accept;

  assign op = cmd_op_t'(cmd_op);
  assign pin_valid = (cmd_pin <= PIN_LAST);
  assign pin_is_bank = (cmd_pin >= PIN_BANK_A_FIRST);
  assign pin_pwm_capable = pin_valid && (cmd_pin != PIN_TIMER_NON_PWM);
  assign op_is_pwm = (op == OP_PERIOD) || (op == OP_DUTY);
  assign period_in_range = (cmd_value >= PERIOD_MIN)
    && (cmd_value <= (pin_is_bank ? BANK_PERIOD_MAX : TIMER_PERIOD_MAX));
  assign slot = period_slot(cmd_pin);
  assign cmd_refused = cmd_valid && (!pin_valid
    || (op_is_pwm && !pin_pwm_capable)
    || ((op == OP_PERIOD) && !period_in_range));
  assign cmd_accept = cmd_valid && !cmd_refused;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < PERIOD_SLOTS; i++)
        period_q[i] <= (i >= TIMER_PWM_CHANNELS) ? BANK_PERIOD_RESET : TIMER_PERIOD_RESET;
      for (int i = 0; i < PIN_COUNT; i++)
        duty_q[i] <= DUTY_RESET;
      pwm_en_q <= PINS_RESET;
      level_q <= PINS_RESET;
    end
    else if (cmd_accept)
    begin
      case (op)
        OP_PERIOD:
          period_q[slot] <= cmd_value;
        OP_DUTY:
        begin
          duty_q[cmd_pin] <= cmd_value;
          pwm_en_q[cmd_pin] <= 1'b1;
        end
        OP_BIT_ON:
        begin
          pwm_en_q[cmd_pin] <= 1'b0;
          level_q[cmd_pin] <= 1'b1;
        end
        OP_BIT_OFF:
        begin
          pwm_en_q[cmd_pin] <= 1'b0;
          level_q[cmd_pin] <= 1'b0;
        end
        default:
          level_q <= level_q;
      endcase
    end
  end

  // one counter per timer pwm channel, one shared by each bank
  genvar g;
  generate
    for (g = 0; g < PERIOD_SLOTS; g++)
    begin : gen_slot
      pwm_period_counter u_cnt (
        .clk(clk),
        .rst(rst),
        .tick(tick),
        .period(period_q[g]),
        .count(slot_cnt[g])
      );
    end
    for (g = 0; g < PIN_COUNT; g++)
    begin : gen_pin
      if (g == PIN_TIMER_NON_PWM)
      begin : gen_bit_only
        assign chan_active[g] = 1'b0;
      end
      else
      begin : gen_pwm
        localparam logic [3:0] S = period_slot(5'(g));
        assign chan_active[g] = (duty_q[g] == DUTY_FULL)
          || ((duty_q[g] != DUTY_OFF)
          && (slot_cnt[S] < active_len(duty_q[g], period_q[S])));
      end
    end
  endgenerate

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      out_q <= PINS_RESET;
    else
      out_q <= (pwm_en_q & chan_active) | (~pwm_en_q & level_q);
  end

  assign pwm_out = out_q;

  // checks
  chk_tick_spacing: assert property (@(posedge clk) disable iff (rst)
    tick |=> !tick [*8] ##1 !tick [*7] ##1 tick)
    else $error("timebase tick spacing is not 16 cycles");

  chk_timer_full_period: assert property (@(posedge clk) disable iff (rst)
    cmd_valid && op == OP_PERIOD && cmd_pin == PIN_TIMER_FIRST && cmd_value == TIMER_PERIOD_MAX
    |=> period_q[0] == TIMER_PERIOD_MAX)
    else $error("timer period 65535 not accepted");

  chk_bank_ceiling: assert property (@(posedge clk) disable iff (rst)
    cmd_valid && op == OP_PERIOD && pin_valid && pin_is_bank && cmd_value > BANK_PERIOD_MAX
    |-> cmd_refused ##1 $stable(period_q[SLOT_BANK_A]) && $stable(period_q[SLOT_BANK_B]))
    else $error("bank period above 32767 not refused");

  chk_bank_shared: assert property (@(posedge clk) disable iff (rst)
    cmd_accept && op == OP_PERIOD && cmd_pin >= PIN_BANK_B_FIRST
    |=> period_q[SLOT_BANK_B] == $past(cmd_value))
    else $error("bank b period not shared");

  chk_period_floor: assert property (@(posedge clk) disable iff (rst)
    cmd_valid && op == OP_PERIOD && cmd_pin == PIN_TIMER_FIRST && cmd_value < PERIOD_MIN
    |-> cmd_refused ##1 $stable(period_q[0]))
    else $error("period below 256 not refused");

  chk_full_on: assert property (@(posedge clk) disable iff (rst)
    pwm_en_q[0] && duty_q[0] == DUTY_FULL |=> pwm_out[0])
    else $error("full scale duty not always on");

  chk_duty_enable: assert property (@(posedge clk) disable iff (rst)
    cmd_accept && op == OP_DUTY && cmd_pin == PIN_TIMER_FIRST |=> pwm_en_q[0] && duty_q[0] == $past(cmd_value))
    else $error("duty write did not start pwm");

  chk_duty_zero_off: assert property (@(posedge clk) disable iff (rst)
    cmd_valid && op == OP_DUTY && cmd_pin == PIN_TIMER_FIRST && cmd_value == DUTY_OFF
    ##1 !(cmd_valid && cmd_pin == PIN_TIMER_FIRST) |=> !pwm_out[0])
    else $error("duty zero did not stop output");

  chk_bit_levels: assert property (@(posedge clk) disable iff (rst)
    cmd_valid && cmd_pin == PIN_BANK_A_FIRST && (op == OP_BIT_ON || op == OP_BIT_OFF)
    ##1 !(cmd_valid && cmd_pin == PIN_BANK_A_FIRST)
    |=> pwm_out[PIN_BANK_A_FIRST] == ($past(op, 2) == OP_BIT_ON))
    else $error("digital on/off level wrong");

  chk_non_pwm_pin: assert property (@(posedge clk) disable iff (rst)
    cmd_valid && op_is_pwm && cmd_pin == PIN_TIMER_NON_PWM |-> cmd_refused ##1 !pwm_en_q[PIN_TIMER_NON_PWM])
    else $error("pwm command on bit-only pin not refused");

  chk_active_time: assert property (@(posedge clk) disable iff (rst)
    pwm_en_q[1] && duty_q[1] != DUTY_FULL && duty_q[1] != DUTY_OFF
    |=> pwm_out[1] == $past(slot_cnt[1] < active_len(duty_q[1], period_q[1])))
    else $error("active time does not match duty times period");

  // timebase and counters
  chk_prescale_range: assert property (@(posedge clk) disable iff (rst)
    tick_cnt_q <= TICK_LAST)
    else $error("prescaler ran past its last state");

  chk_tick_hold: assert property (@(posedge clk) disable iff (rst)
    !tick
    |=> $stable(slot_cnt[0]))
    else $error("period counter moved without a tick");

  // period acceptance and storage
  chk_timer_any_period: assert property (@(posedge clk) disable iff (rst)
    cmd_valid && op == OP_PERIOD && cmd_pin < PIN_TIMER_NON_PWM && cmd_value >= PERIOD_MIN
    |-> !cmd_refused)
    else $error("legal timer period refused");

  chk_period_store: assert property (@(posedge clk) disable iff (rst)
    cmd_accept && op == OP_PERIOD && cmd_pin == 5'h01
    |=> period_q[1] == $past(cmd_value))
    else $error("timer period not stored");

  chk_bank_a_shared: assert property (@(posedge clk) disable iff (rst)
    cmd_accept && op == OP_PERIOD && pin_is_bank && cmd_pin < PIN_BANK_B_FIRST
    |=> period_q[SLOT_BANK_A] == $past(cmd_value))
    else $error("bank a period not shared");

  chk_bank_floor: assert property (@(posedge clk) disable iff (rst)
    cmd_valid && op == OP_PERIOD && cmd_pin >= PIN_BANK_B_FIRST && cmd_pin <= PIN_LAST && cmd_value < PERIOD_MIN
    |-> cmd_refused)
    else $error("bank period below 256 not refused");

  // duty handling
  chk_duty_store: assert property (@(posedge clk) disable iff (rst)
    cmd_accept && op == OP_DUTY && cmd_pin == 5'h01
    |=> duty_q[1] == $past(cmd_value))
    else $error("duty value not stored");

  chk_half_duty: assert property (@(posedge clk) disable iff (rst)
    duty_q[1] == 16'h8000
    |-> active_len(duty_q[1], period_q[1]) == (period_q[1] >> 1))
    else $error("half scale duty is not half the period");

  chk_quarter_duty: assert property (@(posedge clk) disable iff (rst)
    duty_q[1] == 16'h4000
    |-> active_len(duty_q[1], period_q[1]) == (period_q[1] >> 2))
    else $error("quarter scale duty is not a quarter of the period");

  chk_bank_duty_enable: assert property (@(posedge clk) disable iff (rst)
    cmd_accept && op == OP_DUTY && cmd_pin == 5'h13
    |=> pwm_en_q[5'h13])
    else $error("duty write on a bank pin did not start pwm");

  chk_duty_off_low: assert property (@(posedge clk) disable iff (rst)
    pwm_en_q[0] && duty_q[0] == DUTY_OFF
    |=> !pwm_out[0])
    else $error("duty zero output not low");

  chk_bit_off_mode: assert property (@(posedge clk) disable iff (rst)
    cmd_accept && op == OP_BIT_OFF && cmd_pin == 5'h01
    |=> !pwm_en_q[1] && !level_q[1])
    else $error("off command did not stop pwm");

  // digital mode and pin map
  chk_bit_on_mode: assert property (@(posedge clk) disable iff (rst)
    cmd_accept && op == OP_BIT_ON && cmd_pin == PIN_BANK_A_FIRST
    |=> !pwm_en_q[PIN_BANK_A_FIRST] && level_q[PIN_BANK_A_FIRST])
    else $error("on command did not select a high digital level");

  chk_digital_mux: assert property (@(posedge clk) disable iff (rst)
    !pwm_en_q[PIN_BANK_A_FIRST]
    |=> pwm_out[PIN_BANK_A_FIRST] == $past(level_q[PIN_BANK_A_FIRST]))
    else $error("digital pin does not follow its level");

  chk_invalid_pin: assert property (@(posedge clk) disable iff (rst)
    cmd_valid && cmd_pin > PIN_LAST
    |-> cmd_refused)
    else $error("command on a missing pin not refused");

  chk_bit_only_mode: assert property (@(posedge clk) disable iff (rst)
    !pwm_en_q[PIN_TIMER_NON_PWM])
    else $error("bit-only pin entered pwm mode");

  // bit-only pin follows its level; refused commands must leave every pin as it was
  chk_bit_only_level: assert property (@(posedge clk) disable iff (rst)
    1'b1
    |=> pwm_out[PIN_TIMER_NON_PWM] == $past(level_q[PIN_TIMER_NON_PWM]))
    else $error("bit-only pin does not follow its level");

  chk_refused_no_effect: assert property (@(posedge clk) disable iff (rst)
    cmd_refused
    |=> $stable(pwm_en_q) && $stable(level_q))
    else $error("refused command changed a pin mode");
endmodule : pwm_output_generator

// ---- hw/pwm_output_pkg.sv ----
// constants and command codes shared by the pwm output generator
package pwm_output_pkg;
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned TICK_PERIOD_NS = 400;
  localparam int unsigned TICK_DIV = (TICK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] TICK_LAST = 4'(TICK_DIV - 1);
  localparam logic [3:0] TICK_CNT_RESET = 4'h0;

  localparam int unsigned TIMER_PWM_CHANNELS = 13;
  localparam int unsigned BANK_CHANNELS = 6;
  localparam int unsigned PIN_COUNT = 26;
  localparam int unsigned PERIOD_SLOTS = 15;

  // pin index map
  localparam logic [4:0] PIN_TIMER_FIRST = 5'h00;
  localparam logic [4:0] PIN_TIMER_NON_PWM = 5'h0d;
  localparam logic [4:0] PIN_BANK_A_FIRST = 5'h0e;
  localparam logic [4:0] PIN_BANK_B_FIRST = 5'h14;
  localparam logic [4:0] PIN_LAST = 5'h19;
  localparam logic [3:0] SLOT_BANK_A = 4'hd;
  localparam logic [3:0] SLOT_BANK_B = 4'he;

  localparam logic [15:0] PERIOD_MIN = 16'h0100;
  localparam logic [15:0] TIMER_PERIOD_MAX = 16'hffff;
  localparam logic [15:0] BANK_PERIOD_MAX = 16'h7fff;
  localparam logic [15:0] DUTY_FULL = 16'hffff;
  localparam logic [15:0] DUTY_OFF = 16'h0000;

  localparam logic [15:0] TIMER_PERIOD_RESET = 16'hffff;
  localparam logic [15:0] BANK_PERIOD_RESET = 16'h7fff;
  localparam logic [15:0] DUTY_RESET = 16'h0000;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [25:0] PINS_RESET = 26'h0000000;

  typedef enum logic [1:0] {
    OP_PERIOD,
    OP_DUTY,
    OP_BIT_ON,
    OP_BIT_OFF
  } cmd_op_t;
endpackage : pwm_output_pkg

// ---- hw/pwm_period_counter.sv ----
// period counter stepped by the timebase tick, shared by one or more channels
module pwm_period_counter
  import pwm_output_pkg::*;
(
  input wire logic clk, // 40 MHz clock
  input wire logic rst, // async reset, active high
  input wire logic tick, // one-cycle timebase tick
  input wire logic [15:0] period, // period in ticks
  output logic [15:0] count // position within the period
);
  logic [15:0] count_q;
  logic [15:0] count_d;
  logic at_end;

  // the end check uses >= so a shortened period never overruns
  assign at_end = (count_q >= 16'(period - 16'h0001));
  assign count_d = !tick ? count_q : (at_end ? COUNT_RESET : 16'(count_q + 16'h0001));
  assign count = count_q;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      count_q <= COUNT_RESET;
    end
    else
    begin
      count_q <= count_d;
    end
  end
endmodule : pwm_period_counter

// ---- verif/pulse_monitor.sv ----
// far-side load model: measures period and high time of one pwm pin in clocks
module pulse_monitor
(
  input wire logic clk, // bench clock
  input wire logic level, // observed pin level
  output logic [31:0] period_q, // clocks between rising edges
  output logic [31:0] high_q // high clocks in the last period
);
  timeunit 1ns;
  timeprecision 1ps;
  logic prev_q;
  logic [31:0] run_q;
  logic [31:0] hrun_q;
  always_ff @(posedge clk)
  begin
    prev_q <= level;
    if (level && !prev_q)
    begin
      period_q <= run_q;
      high_q <= hrun_q;
      run_q <= 32'h1;
      hrun_q <= 32'h1;
    end
    else
    begin
      run_q <= run_q + 32'h1;
      hrun_q <= hrun_q + {31'h0, level};
    end
  end
endmodule : pulse_monitor

// ---- verif/tb_pwm_output_generator.sv ----
// self-checking bench for the pwm output generator
`define CHECK(a, e, m) begin check_count++; if ((a) !== (e)) begin fails++; $display("Error %0t: %s", $time, m); end end
module tb_pwm_output_generator
  import pwm_output_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cmd_valid = 1'b0;
  logic [1:0] cmd_op = 2'h0;
  logic [4:0] cmd_pin = 5'h00;
  logic [15:0] cmd_value = 16'h0000;
  logic cmd_refused;
  logic [25:0] pwm_out;
  logic [4:0] sel = 5'h00;
  logic [31:0] per_cyc;
  logic [31:0] hi_cyc;
  int fails = 0;
  int check_count = 0;
  always #12.5 clk = ~clk;
  pwm_output_generator pwm_output_generator_inst (.clk(clk), .rst(rst), .cmd_valid(cmd_valid),
    .cmd_op(cmd_op), .cmd_pin(cmd_pin), .cmd_value(cmd_value), .cmd_refused(cmd_refused), .pwm_out(pwm_out));
  pulse_monitor pulse_monitor_inst (.clk(clk), .level(pwm_out[sel]), .period_q(per_cyc), .high_q(hi_cyc));
  task automatic summarize;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : summarize
  task automatic send(input cmd_op_t op, input logic [4:0] pin, input logic [15:0] val, input logic exp);
    @(negedge clk);
    cmd_valid = 1'b1;
    cmd_op = op;
    cmd_pin = pin;
    cmd_value = val;
    #2;
    `CHECK(cmd_refused, exp, "refusal flag")
    @(negedge clk);
    cmd_valid = 1'b0;
  endtask : send
  // per and hi in clocks; one tick is 16 clocks
  task automatic measure(input logic [4:0] pin, input logic [31:0] per, input logic [31:0] hi);
    sel = pin;
    repeat (3 * per) @(posedge clk);
    #1;
    `CHECK(per_cyc, per, "pwm period")
    `CHECK(hi_cyc, hi, "pwm high time")
  endtask : measure
  task automatic hold_check(input logic [4:0] pin, input logic lvl);
    repeat (8)
    begin
      repeat (600) @(negedge clk);
      `CHECK(pwm_out[pin], lvl, "steady level")
    end
  endtask : hold_check
  task automatic test_refuse;
    send(OP_PERIOD, 5'h00, 16'h00ff, 1'b1);
    send(OP_PERIOD, 5'h14, 16'h00ff, 1'b1);
    send(OP_PERIOD, 5'h0e, 16'h8000, 1'b1);
    send(OP_PERIOD, 5'h19, 16'h7fff, 1'b0);
    send(OP_PERIOD, 5'h00, 16'hffff, 1'b0);
    send(OP_PERIOD, 5'h0d, 16'h0100, 1'b1);
    send(OP_BIT_ON, 5'h1a, 16'h0000, 1'b1);
    $display("test refuse done");
  endtask : test_refuse
  task automatic test_bits;
    send(OP_BIT_ON, 5'h0d, 16'h0000, 1'b0);
    send(OP_BIT_ON, 5'h0e, 16'h0000, 1'b0);
    @(negedge clk);
    `CHECK(pwm_out[13], 1'b1, "bit on")
    `CHECK(pwm_out[14], 1'b1, "bit on")
    send(OP_DUTY, 5'h0d, 16'h8000, 1'b1);
    repeat (40) @(negedge clk);
    `CHECK(pwm_out[13], 1'b1, "bit pin kept")
    send(OP_BIT_OFF, 5'h0d, 16'h0000, 1'b0);
    send(OP_BIT_OFF, 5'h0e, 16'h0000, 1'b0);
    @(negedge clk);
    `CHECK(pwm_out[14:13], 2'h0, "bit off")
    $display("test bits done");
  endtask : test_bits
  task automatic test_duty;
    send(OP_PERIOD, 5'h01, 16'h0100, 1'b0);
    send(OP_DUTY, 5'h01, 16'h8000, 1'b0);
    measure(5'h01, 32'd4096, 32'd2048);
    send(OP_DUTY, 5'h01, 16'h4000, 1'b0);
    measure(5'h01, 32'd4096, 32'd1024);
    send(OP_BIT_OFF, 5'h01, 16'h0000, 1'b0);
    @(negedge clk);
    hold_check(5'h01, 1'b0);
    $display("test duty done");
  endtask : test_duty
  task automatic test_bank;
    send(OP_PERIOD, 5'h0e, 16'h0200, 1'b0);
    send(OP_DUTY, 5'h13, 16'h8000, 1'b0);
    measure(5'h13, 32'd8192, 32'd4096);
    send(OP_PERIOD, 5'h19, 16'h0100, 1'b0);
    send(OP_DUTY, 5'h16, 16'h4000, 1'b0);
    measure(5'h16, 32'd4096, 32'd1024);
    $display("test bank done");
  endtask : test_bank
  task automatic test_levels;
    send(OP_PERIOD, 5'h00, 16'h0100, 1'b0);
    send(OP_DUTY, 5'h00, 16'hffff, 1'b0);
    hold_check(5'h00, 1'b1);
    send(OP_DUTY, 5'h00, 16'h0000, 1'b0);
    hold_check(5'h00, 1'b0);
    $display("test levels done");
  endtask : test_levels
  initial
  begin
    repeat (6) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    `CHECK(pwm_out, 26'h0, "reset level")
    test_refuse();
    test_bits();
    test_duty();
    test_bank();
    test_levels();
    summarize();
  end
  initial
  begin
    repeat (95000) @(posedge clk);
    fails++;
    summarize();
  end
endmodule : tb_pwm_output_generator
